// >>> stc_pkg.sv
// Shared constants and types for the supervisor threshold configuration block.
// Assumes a single 40 MHz clock and a two-wire configuration bus.
package stc_pkg;

   // ***************************************************************
   // Clock and timing
   // ***************************************************************
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned NUM_TIMEOUTS  = 8;
   localparam int unsigned TO_SEL_W      = 3;

   // Output timeouts: 25 us, 1.5625 ms, 6.25 ms, 25 ms, 50 ms, 200 ms, 400 ms, 1.6 s.
   localparam int unsigned TIMEOUT_NS [NUM_TIMEOUTS] = '{
      25000, 1562500, 6250000, 25000000, 50000000, 200000000, 400000000, 1600000000};

   // Least times round up to whole cycles.
   function automatic int unsigned ns_to_cycles(input int unsigned ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   localparam int unsigned TIMEOUT_CYC [NUM_TIMEOUTS] = '{
      ns_to_cycles(TIMEOUT_NS[0]), ns_to_cycles(TIMEOUT_NS[1]),
      ns_to_cycles(TIMEOUT_NS[2]), ns_to_cycles(TIMEOUT_NS[3]),
      ns_to_cycles(TIMEOUT_NS[4]), ns_to_cycles(TIMEOUT_NS[5]),
      ns_to_cycles(TIMEOUT_NS[6]), ns_to_cycles(TIMEOUT_NS[7])};

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int unsigned NUM_RAILS     = 8;
   localparam int unsigned NUM_CFG       = 10;
   localparam logic [7:0]  REG_THR_A     = 8'h00;
   localparam logic [7:0]  REG_THR_H     = 8'h07;
   localparam logic [7:0]  REG_SCALE     = 8'h08;
   localparam logic [7:0]  REG_IMPED     = 8'h09;
   localparam logic [7:0]  REG_AUX_POL   = 8'h28;
   localparam logic [7:0]  REG_RAIL_STAT = 8'h2A;
   localparam logic [7:0]  REG_PIN_STAT  = 8'h2B;
   localparam logic [7:0]  CFG_RESET     = 8'h00;
   localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

   // ***************************************************************
   // Serial bus
   // ***************************************************************
   localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h2C;
   localparam logic [3:0]  BYTE_BITS        = 4'h8;
   localparam logic [3:0]  LAST_TX_BIT      = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RX     = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX     = 3'b011,
      ST_TX_ACK = 3'b100
   } stc_bus_state_t;

endpackage

// >>> stc_threshold_config.sv
// Threshold, scale and impedance registers of a multi-rail supervisor, reached
// over a two-wire serial bus, plus auxiliary input polarity and manual reset.
// Assumes one clock; bus pins, manual reset, auxiliary inputs and comparator
// results arrive asynchronously and are synchronised here.

// Contract
// - Register 00h holds the eight-bit threshold code of rail a.
// - Scale bit 0 picks rail a's coarse or fine threshold scale.
// - Registers 01h to 06h hold threshold codes of rails b to g.
// - Scale bits 1 to 6 pick coarse or fine scale for rails b to g.
// - Impedance bits 1 to 6 put rails b to g in high-impedance mode.
// - Register 07h holds the eight-bit threshold code of rail h.
// - Scale bit 7 picks rail h's coarse or fine threshold scale.
// - Impedance bit 7 puts rail h in high-impedance mode.
// - Each auxiliary input has its own programmable active polarity.
// - Asserted auxiliary inputs are offered to outputs, reset and watchdog logic; here they only reach aux_asserted and the pin status register.
// - Low manual reset asserts every sequenced output that depends on it.
// - After manual reset release, outputs stay asserted for their own timeout.
// - Each output timeout is one of eight selectable periods.
// - A rail below threshold presents logic 0 to the output logic.
module stc_threshold_config #(
   parameter logic [6:0]  DEV_ADDR = stc_pkg::DEV_ADDR_DEFAULT,
   parameter int unsigned NUM_AUX  = 4,
   parameter int unsigned NUM_OUT  = 10,
   parameter int unsigned TO_CYC [stc_pkg::NUM_TIMEOUTS] = stc_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst,
   // Two-wire configuration bus
   input  wire logic                              scl,
   input  wire logic                              sda_in,
   output logic                                   sda_out,
   output logic                                   sda_oe,
   // Detector configuration towards the analog front end
   output logic [8*stc_pkg::NUM_RAILS-1:0]        rail_threshold_code,
   output logic [stc_pkg::NUM_RAILS-1:0]          rail_scale_select,
   output logic [stc_pkg::NUM_RAILS-1:0]          rail_high_impedance,
   // Detector results
   input  wire logic [stc_pkg::NUM_RAILS-1:0]     comparator_above,
   output logic [stc_pkg::NUM_RAILS-1:0]          rail_ok,
   // Auxiliary logic inputs
   input  wire logic [NUM_AUX-1:0]                aux_logic_inputs,
   output logic [NUM_AUX-1:0]                     aux_asserted,
   // Manual reset and sequenced outputs
   input  wire logic                              manual_reset_n,
   input  wire logic [NUM_OUT-1:0]                mr_dependency,
   input  wire logic [stc_pkg::TO_SEL_W*NUM_OUT-1:0] timeout_select,
   output logic [NUM_OUT-1:0]                     sequenced_outputs
);

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************
   localparam int unsigned SW = 3 + NUM_AUX + stc_pkg::NUM_RAILS;
   localparam logic [SW-1:0] SYNC_IDLE = {3'b111, {(SW-3){1'b0}}};

   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic [SW-1:0] sync3_q;
   logic [SW-1:0] filt_q;
   logic          scl_f;
   logic          sda_f;
   logic          mr_n_f;
   logic          scl_prev_q;
   logic          sda_prev_q;

   // A bit changes once the second and third stages agree.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
         sync3_q <= SYNC_IDLE;
         filt_q  <= SYNC_IDLE;
      end else begin
         sync1_q <= {scl, sda_in, manual_reset_n, aux_logic_inputs, comparator_above};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q  <= (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));
      end
   end

   assign scl_f  = filt_q[SW-1];
   assign sda_f  = filt_q[SW-2];
   assign mr_n_f = filt_q[SW-3];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   assign scl_rise = scl_f & ~scl_prev_q;
   assign scl_fall = ~scl_f & scl_prev_q;
   assign start_ev = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
   assign stop_ev  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

   // ***************************************************************
   // Register file
   // ***************************************************************
   logic [7:0]         cfg_q [stc_pkg::NUM_CFG];
   logic [NUM_AUX-1:0] pol_q;
   logic [NUM_AUX-1:0] aux_asserted_q;
   logic [stc_pkg::NUM_RAILS-1:0] rail_ok_q;
   logic               wr_stb_q;
   logic [7:0]         wr_addr_q;
   logic [7:0]         wr_data_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < stc_pkg::NUM_CFG; i++) begin
            cfg_q[i] <= stc_pkg::CFG_RESET;
         end
         pol_q <= '0;
      end else if (wr_stb_q) begin
         if (wr_addr_q <= stc_pkg::REG_IMPED) begin
            cfg_q[wr_addr_q[3:0]] <= wr_data_q;
         end
         if (wr_addr_q == stc_pkg::REG_AUX_POL) begin
            pol_q <= wr_data_q[NUM_AUX-1:0];
         end
      end
   end

   // Threshold codes, scale and impedance bits steer the analog detectors.
   always_comb begin
      for (int i = 0; i < stc_pkg::NUM_RAILS; i++) begin
         rail_threshold_code[8*i +: 8] = cfg_q[i];
      end
   end
   assign rail_scale_select   = cfg_q[stc_pkg::REG_SCALE[3:0]];
   assign rail_high_impedance = cfg_q[stc_pkg::REG_IMPED[3:0]];

   // ***************************************************************
   // Detector results and auxiliary inputs
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rail_ok_q      <= '0;
         aux_asserted_q <= '0;
      end else begin
         rail_ok_q      <= filt_q[stc_pkg::NUM_RAILS-1:0];
         aux_asserted_q <= filt_q[stc_pkg::NUM_RAILS +: NUM_AUX] ~^ pol_q;
      end
   end
   assign rail_ok      = rail_ok_q;
   assign aux_asserted = aux_asserted_q;

   // ***************************************************************
   // Manual reset hold
   // ***************************************************************
   logic [NUM_OUT-1:0] hold_q;
   logic [31:0]        cnt_q [NUM_OUT];

   // The timeout reloads while manual reset is low and runs after release.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_q <= '0;
         for (int i = 0; i < NUM_OUT; i++) begin
            cnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_OUT; i++) begin
            if (!mr_n_f && mr_dependency[i]) begin
               hold_q[i] <= 1'b1;
               cnt_q[i]  <= TO_CYC[timeout_select[stc_pkg::TO_SEL_W*i +: stc_pkg::TO_SEL_W]];
            end else if (hold_q[i]) begin
               if (cnt_q[i] == '0) begin
                  hold_q[i] <= 1'b0;
               end else begin
                  cnt_q[i] <= cnt_q[i] - 32'h1;
               end
            end
         end
      end
   end
   assign sequenced_outputs = hold_q;

   // ***************************************************************
   // Serial bus slave
   // ***************************************************************
   stc_pkg::stc_bus_state_t state_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic       first_q;
   logic       have_ptr_q;
   logic       rw_q;
   logic       nack_q;
   logic       sda_oe_q;
   logic [7:0] tx_byte;
   // Read data is decoded in a process so that register changes reach it directly.
   always_comb begin
      tx_byte = stc_pkg::UNMAPPED_DATA;
      if (ptr_q <= stc_pkg::REG_IMPED) begin
         tx_byte = cfg_q[ptr_q[3:0]];
      end else if (ptr_q == stc_pkg::REG_AUX_POL) begin
         tx_byte[NUM_AUX-1:0] = pol_q;
      end else if (ptr_q == stc_pkg::REG_RAIL_STAT) begin
         tx_byte = rail_ok_q;
      end else if (ptr_q == stc_pkg::REG_PIN_STAT) begin
         tx_byte[NUM_AUX]     = mr_n_f;
         tx_byte[NUM_AUX-1:0] = aux_asserted_q;
      end
   end

   // Open drain: the line is only ever pulled low.
   assign sda_out = 1'b0;
   assign sda_oe  = sda_oe_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q    <= stc_pkg::ST_IDLE;
         bit_q      <= '0;
         shift_q    <= '0;
         ptr_q      <= '0;
         first_q    <= 1'b0;
         have_ptr_q <= 1'b0;
         rw_q       <= 1'b0;
         nack_q     <= 1'b0;
         sda_oe_q   <= 1'b0;
         wr_stb_q   <= 1'b0;
         wr_addr_q  <= '0;
         wr_data_q  <= '0;
      end else begin
         wr_stb_q <= 1'b0;
         if (start_ev) begin
            state_q    <= stc_pkg::ST_RX;
            bit_q      <= '0;
            first_q    <= 1'b1;
            have_ptr_q <= 1'b0;
            sda_oe_q   <= 1'b0;
         end else if (stop_ev) begin
            state_q  <= stc_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            unique case (state_q)
               stc_pkg::ST_IDLE: begin
                  sda_oe_q <= 1'b0;
               end
               stc_pkg::ST_RX: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_f};
                     bit_q   <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == stc_pkg::BYTE_BITS) begin
                     bit_q <= '0;
                     if (first_q && shift_q[7:1] != DEV_ADDR) begin
                        state_q <= stc_pkg::ST_IDLE;
                     end else begin
                        state_q  <= stc_pkg::ST_RX_ACK;
                        sda_oe_q <= 1'b1;
                        if (first_q) begin
                           rw_q    <= shift_q[0];
                           first_q <= 1'b0;
                        end else if (!have_ptr_q) begin
                           ptr_q      <= shift_q;
                           have_ptr_q <= 1'b1;
                        end else begin
                           wr_stb_q  <= 1'b1;
                           wr_addr_q <= ptr_q;
                           wr_data_q <= shift_q;
                           ptr_q     <= ptr_q + 8'h01;
                        end
                     end
                  end
               end
               stc_pkg::ST_RX_ACK: begin
                  if (scl_fall) begin
                     if (rw_q) begin
                        shift_q  <= tx_byte;
                        sda_oe_q <= ~tx_byte[7];
                        ptr_q    <= ptr_q + 8'h01;
                        state_q  <= stc_pkg::ST_TX;
                     end else begin
                        sda_oe_q <= 1'b0;
                        state_q  <= stc_pkg::ST_RX;
                     end
                  end
               end
               stc_pkg::ST_TX: begin
                  if (scl_fall) begin
                     if (bit_q == stc_pkg::LAST_TX_BIT) begin
                        bit_q    <= '0;
                        sda_oe_q <= 1'b0;
                        state_q  <= stc_pkg::ST_TX_ACK;
                     end else begin
                        shift_q  <= {shift_q[6:0], 1'b0};
                        sda_oe_q <= ~shift_q[6];
                        bit_q    <= bit_q + 4'h1;
                     end
                  end
               end
               stc_pkg::ST_TX_ACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_f;
                  end else if (scl_fall) begin
                     if (nack_q) begin
                        state_q <= stc_pkg::ST_IDLE;
                     end else begin
                        shift_q  <= tx_byte;
                        sda_oe_q <= ~tx_byte[7];
                        ptr_q    <= ptr_q + 8'h01;
                        state_q  <= stc_pkg::ST_TX;
                     end
                  end
               end
               default: begin
                  state_q <= stc_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   thr_a_write_a: assert property (wr_stb_q && wr_addr_q == stc_pkg::REG_THR_A
      |=> rail_threshold_code[7:0] == $past(wr_data_q))
      else $error("rail a threshold code not stored");
   thr_h_write_a: assert property (wr_stb_q && wr_addr_q == stc_pkg::REG_THR_H
      |=> rail_threshold_code[63:56] == $past(wr_data_q))
      else $error("rail h threshold code not stored");
   thr_mid_write_a: assert property (wr_stb_q && wr_addr_q == 8'h03
      |=> ##1 rail_threshold_code[31:24] == $past(wr_data_q, 2))
      else $error("rail d threshold code not stored");
   scale_write_a: assert property (wr_stb_q && wr_addr_q == stc_pkg::REG_SCALE
      |=> rail_scale_select == $past(wr_data_q))
      else $error("scale select not stored");
   imped_write_a: assert property (wr_stb_q && wr_addr_q == stc_pkg::REG_IMPED
      |=> rail_high_impedance == $past(wr_data_q))
      else $error("impedance mode not stored");
   read_back_a: assert property ((state_q == stc_pkg::ST_RX_ACK) && rw_q && scl_fall
      && ptr_q <= stc_pkg::REG_IMPED |=> shift_q == cfg_q[$past(ptr_q[3:0])])
      else $error("read data differs from register");
   rail_fault_a: assert property (!filt_q[0] |=> !rail_ok[0])
      else $error("fault not presented as logic 0");
   mr_assert_a: assert property (!mr_n_f && mr_dependency[0] |=> sequenced_outputs[0])
      else $error("manual reset did not assert output");
   mr_timeout_a: assert property (!mr_n_f && mr_dependency[0] && timeout_select[2:0] == 3'h0
      |=> cnt_q[0] == TO_CYC[0])
      else $error("timeout not loaded with selected period");
   mr_hold_a: assert property (sequenced_outputs[0] && cnt_q[0] != '0
      |=> sequenced_outputs[0])
      else $error("output released before timeout");
   aux_pol_a: assert property (pol_q[0] && filt_q[stc_pkg::NUM_RAILS]
      |=> aux_asserted[0])
      else $error("active-high auxiliary input not asserted");

   bus_write_c: cover property (wr_stb_q);
   bus_read_c: cover property (state_q == stc_pkg::ST_TX_ACK && scl_fall && !nack_q);
   mr_release_c: cover property (sequenced_outputs[0] ##1 !sequenced_outputs[0]);
   addr_nack_c: cover property (state_q == stc_pkg::ST_RX ##1 state_q == stc_pkg::ST_IDLE);

endmodule

// >>> stc_host_model.sv
// Host controller model on the two-wire configuration bus.
// Assumes the bench resolves sda_line from all open-drain drivers with a pull-up.
module stc_host_model #(
   parameter logic [6:0] ADDR = 7'h2C
) (
   // Clock and bus
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      scl = 1'h1;
      sda_drv = 1'h1;
   end

   // Each bus phase lasts ten clocks, above the eight-clock minimum.
   task automatic tick();
      repeat (10) @(posedge clk);
      #1;
   endtask

   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      tick();
      scl = 1'h1;
      tick();
      r = sda_line;
      scl = 1'h0;
      tick();
   endtask

   task automatic byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                          output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ak, nak);
   endtask

   task automatic start();
      sda_drv = 1'h1;
      tick();
      scl = 1'h1;
      tick();
      sda_drv = 1'h0;
      tick();
      scl = 1'h0;
      tick();
   endtask

   task automatic stop();
      sda_drv = 1'h0;
      tick();
      scl = 1'h1;
      tick();
      sda_drv = 1'h1;
      tick();
   endtask

   // Write burst from pointer p; nak collects every missing acknowledge.
   task automatic wr(input logic [7:0] p, input logic [7:0] d[$], input logic [6:0] a,
                     output logic nak);
      logic [7:0] rx;
      logic       n;
      start();
      byte_io({a, 1'h0}, 1'h1, rx, nak);
      byte_io(p, 1'h1, rx, n);
      nak = nak | n;
      foreach (d[i]) begin
         byte_io(d[i], 1'h1, rx, n);
         nak = nak | n;
      end
      stop();
   endtask

   // Read burst of n bytes from pointer p, the last byte refused.
   task automatic rd(input logic [7:0] p, input int n, output logic [7:0] q[$]);
      logic [7:0] rx;
      logic       k;
      q = {};
      start();
      byte_io({ADDR, 1'h0}, 1'h1, rx, k);
      byte_io(p, 1'h1, rx, k);
      start();
      byte_io({ADDR, 1'h1}, 1'h1, rx, k);
      for (int i = 0; i < n; i++) begin
         byte_io(8'hFF, (i == n - 1), rx, k);
         q.push_back(rx);
      end
      stop();
   endtask
endmodule

// >>> tb_supervisor_threshold_config.sv
// Self-checking bench for the supervisor threshold configuration block.
// Assumes the host model drives the bus; expectations come from a register model.
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_supervisor_threshold_config;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned NOUT = 10;
   localparam int unsigned TO_SIM [8] = '{4, 8, 12, 16, 20, 24, 28, 32};
   localparam logic [6:0]  DEV = stc_pkg::DEV_ADDR_DEFAULT;
   logic              clk = 1'h0;
   logic              rst = 1'h1;
   logic              manual_reset_n = 1'h1;
   logic              scl, sda_drv, sda_out, sda_oe, nak;
   wire logic         sda_line;
   logic [63:0]       thr;
   logic [7:0]        scale, imped, rok, v;
   logic [7:0]        cmp = 8'h00;
   logic [3:0]        aux = 4'h0;
   logic [3:0]        aux_as, pol;
   logic [NOUT-1:0]   dep = '0;
   logic [NOUT-1:0]   seq, stray;
   logic [3*NOUT-1:0] tsel = '0;
   logic [7:0]        model [10];
   logic [7:0]        q [$];
   logic [7:0]        d [$];
   int                drop [NOUT];
   int                off;
   int                seed = 69522;
   int                n_fail = 0;
   int                total_checks = 0;

   always #12.5 clk = ~clk;
   assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

   stc_threshold_config #(.TO_CYC(TO_SIM)) u_dut (
      .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .rail_threshold_code(thr), .rail_scale_select(scale),
      .rail_high_impedance(imped), .comparator_above(cmp), .rail_ok(rok),
      .aux_logic_inputs(aux), .aux_asserted(aux_as), .manual_reset_n(manual_reset_n),
      .mr_dependency(dep), .timeout_select(tsel), .sequenced_outputs(seq));

   stc_host_model #(.ADDR(DEV)) u_host (
      .clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

   task automatic close_out();
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check_outputs();
      for (int i = 0; i < 8; i++) begin
         `CHK("threshold", model[i], thr[8*i +: 8])
      end
      `CHK("scale", model[8], scale)
      `CHK("impedance", model[9], imped)
   endtask

   initial begin
      repeat (16) @(posedge clk);
      #1;
      rst = 1'h0;
      repeat (6) @(posedge clk);
      #1;
      foreach (model[i]) model[i] = 8'h00;
      check_outputs();
      `CHK("outputs after reset", '0, seq)
      // Bursts from offset 0; the last round pushes every code to its ceiling.
      for (int r = 0; r < 3; r++) begin
         d = {};
         for (int i = 0; i < 10; i++) begin
            v = (r == 2) ? 8'hFF : 8'($random(seed));
            if (i == 0 && v > 8'hD6) v = 8'hD6;
            if (i >= 1 && i <= 6 && v > 8'hE1) v = 8'hE1;
            if (i == 9) v[0] = 1'h0;
            model[i] = v;
            d.push_back(v);
         end
         u_host.wr(8'h00, d, DEV, nak);
         `CHK("write ack", 1'h0, nak)
         check_outputs();
         u_host.rd(8'h00, 10, q);
         foreach (model[i]) `CHK("readback", model[i], q[i])
      end
      d = {8'h5A};
      u_host.wr(8'h00, d, 7'h15, nak);
      `CHK("foreign address nak", 1'h1, nak)
      check_outputs();
      u_host.wr(8'h30, d, DEV, nak);
      `CHK("unmapped write ack", 1'h0, nak)
      check_outputs();
      u_host.rd(8'h30, 1, q);
      `CHK("unmapped read", stc_pkg::UNMAPPED_DATA, q[0])
      for (int r = 0; r < 4; r++) begin
         pol = (r == 0) ? 4'hF : (r == 1) ? 4'h0 : 4'($random(seed));
         aux = (r == 0) ? 4'hF : (r == 1) ? 4'h0 : 4'($random(seed));
         cmp = 8'($random(seed));
         d = {{4'h0, pol}};
         u_host.wr(stc_pkg::REG_AUX_POL, d, DEV, nak);
         `CHK("aux asserted", ~(aux ^ pol), aux_as)
         `CHK("rail ok", cmp, rok)
         u_host.rd(stc_pkg::REG_AUX_POL, 4, q);
         `CHK("polarity read", {4'h0, pol}, q[0])
         `CHK("gap read", stc_pkg::UNMAPPED_DATA, q[1])
         `CHK("rail status read", cmp, q[2])
         `CHK("pin status read", {3'h0, 1'h1, ~(aux ^ pol)}, q[3])
      end
      // Manual reset: first every timeout code, then random dependencies and codes.
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < NOUT; i++) tsel[3*i +: 3] = (r == 0) ? 3'(i % 8) : 3'($random(seed));
         dep = (r == 0) ? '1 : NOUT'($random(seed));
         dep[0] = 1'h1;
         manual_reset_n = 1'h0;
         repeat (8) @(posedge clk);
         #1;
         `CHK("manual reset assert", dep, seq)
         manual_reset_n = 1'h1;
         stray = '0;
         foreach (drop[i]) drop[i] = 0;
         for (int t = 1; t <= 100; t++) begin
            @(posedge clk);
            #1;
            stray = stray | (seq & ~dep);
            for (int i = 0; i < NOUT; i++) if (dep[i] && !seq[i] && drop[i] == 0) drop[i] = t;
         end
         `CHK("outputs released", '0, seq)
         `CHK("independent outputs", '0, stray)
         off = drop[0] - int'(TO_SIM[tsel[2:0]]);
         `CHK("release latency", 1'h1, off >= 3 && off <= 7)
         for (int i = 1; i < NOUT; i++) begin
            if (dep[i]) `CHK("timeout length", off, drop[i] - int'(TO_SIM[tsel[3*i +: 3]]))
         end
      end
      close_out();
   end
endmodule
